// *** rebh_pkg.sv ***
// Constants, types and the ECC check function for the RAM error bank handler
package rebh_pkg;

   localparam int REBH_NBANK = 5;
   localparam int REBH_MAXDEPTH = 3;
   localparam int REBH_LOC_W = 12;
   localparam int REBH_CW_W = 39;
   localparam int REBH_CNT_W = 16;
   // Bank depths per RAM
   localparam logic [1:0] REBH_DEPTH_L1 = 2'h3;
   localparam logic [1:0] REBH_DEPTH_SCU = 2'h2;
   localparam logic [1:0] REBH_DEPTH_TCM = 2'h1;
   // Auxiliary control check enables, both bits set
   localparam logic [1:0] REBH_AUX_CORR_ON = 2'h3;
   localparam logic [REBH_CNT_W-1:0] REBH_CNT_RST = 16'h0000;

   typedef enum logic [2:0] {
      REBH_SRC_ICACHE = 3'h0,
      REBH_SRC_DCACHE = 3'h1,
      REBH_SRC_SCU = 3'h2,
      REBH_SRC_ITCM = 3'h3,
      REBH_SRC_DTCM = 3'h4,
      REBH_SRC_BRANCH = 3'h5
   } rebh_src_t;

   typedef enum logic [1:0] {
      REBH_ERR_NONE = 2'h0,
      REBH_ERR_SINGLE = 2'h1,
      REBH_ERR_MULTI = 2'h2
   } rebh_err_t;

   typedef enum logic [1:0] {
      REBH_OP_INV = 2'h1,
      REBH_OP_CLEAN_INV = 2'h2
   } rebh_op_t;

   // Gray codes along idle, maintenance, retry path
   typedef enum logic [2:0] {
      REBH_ST_IDLE = 3'h0,
      REBH_ST_MAINT = 3'h1,
      REBH_ST_WB = 3'h3,
      REBH_ST_SCU_MARK = 3'h5
   } rebh_state_t;

   typedef struct packed {
      rebh_src_t src;
      logic [REBH_LOC_W-1:0] loc;
      logic [REBH_CW_W-1:0] code;
   } rebh_rd_t;

   typedef struct packed {
      rebh_src_t src;
      logic [1:0] entry;
   } rebh_clr_t;

   typedef struct packed {
      rebh_src_t src;
      logic [REBH_LOC_W-1:0] loc;
   } rebh_look_t;

   typedef struct packed {
      rebh_err_t kind;
      logic [REBH_CW_W-1:0] fixed;
   } rebh_chk_t;

   // Codeword bits 38..1 are Hamming positions, bit 0 is overall parity
   function automatic rebh_chk_t rebh_secded(input logic [REBH_CW_W-1:0] cw);
      logic [5:0] syn;
      logic par;
      rebh_chk_t r;
      syn = 6'h00;
      par = ^cw;
      r.fixed = cw;
      for (int i = 1; i < REBH_CW_W; i++) begin
         if (cw[i]) begin
            syn = syn ^ 6'(i);
         end
      end
      if (!par && syn == 6'h00) begin
         r.kind = REBH_ERR_NONE;
      end else if (par) begin
         r.kind = REBH_ERR_SINGLE;
         if (syn < 6'(REBH_CW_W)) begin
            r.fixed[syn] = ~cw[syn];
         end else begin
            r.kind = REBH_ERR_MULTI;
         end
      end else begin
         r.kind = REBH_ERR_MULTI;
      end
      return r;
   endfunction : rebh_secded

endpackage : rebh_pkg

// *** rebh_top.sv ***
// RAM ECC error detection, correction sequencing and error banks
`timescale 1ns/1ns
module rebh_top (
   // Clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_RSTN,
   // Read check port
   input wire logic I_RD_VALID,
   input rebh_pkg::rebh_rd_t I_RD,
   input wire logic [1:0] I_AUX_ECC_EN,
   // Maintenance and write back handshakes
   input wire logic I_MAINT_DONE,
   input wire logic I_WB_DONE,
   // Bank clear and lookup
   input wire logic I_CLR_VALID,
   input rebh_pkg::rebh_clr_t I_CLR,
   input rebh_pkg::rebh_look_t I_LOOK,
   // Sequencing outputs
   output logic O_BUSY,
   output logic O_MAINT_REQ,
   output rebh_pkg::rebh_op_t O_MAINT_OP,
   output logic [rebh_pkg::REBH_LOC_W-1:0] O_MAINT_LOC,
   output logic O_WB_VALID,
   output logic [rebh_pkg::REBH_CW_W-1:0] O_WB_DATA,
   output logic O_RETRY,
   output rebh_pkg::rebh_src_t O_RETRY_SRC,
   output logic [rebh_pkg::REBH_LOC_W-1:0] O_RETRY_LOC,
   output logic O_RETRY_FROM_BANK,
   output logic [rebh_pkg::REBH_CW_W-1:0] O_RETRY_DATA,
   // Lookup result
   output logic O_LOOK_MASKED,
   // Events and status
   output logic O_EVT_CORR,
   output logic O_EVT_FATAL,
   output logic O_EVT_PARITY,
   output logic O_RAM_FAULT_OUT,
   output logic [rebh_pkg::REBH_NBANK-1:0] O_BANK_NONEMPTY,
   output logic [rebh_pkg::REBH_NBANK-1:0][1:0] O_BANK_COUNT,
   output logic [rebh_pkg::REBH_CNT_W-1:0] O_ERR_COUNT,
   output logic [rebh_pkg::REBH_CNT_W-1:0] O_CORR_COUNT
);
   import rebh_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   rebh_state_t state_reg;
   rebh_src_t cap_src_reg;
   logic [REBH_LOC_W-1:0] cap_loc_reg;
   logic [REBH_CW_W-1:0] cap_fix_reg;
   logic cap_bank_reg;
   logic watch_reg;
   rebh_src_t watch_src_reg;
   logic [REBH_LOC_W-1:0] watch_loc_reg;
   logic [REBH_NBANK-1:0][REBH_MAXDEPTH-1:0] vld_reg;
   logic [REBH_NBANK-1:0][REBH_MAXDEPTH-1:0][REBH_LOC_W-1:0] loc_reg;
   logic [1:0][REBH_CW_W-1:0] tcm_copy_reg;

   rebh_chk_t chk;
   logic take;
   logic is_branch;
   logic is_tcm;
   logic ecc_err;
   logic tcm_first;
   logic [REBH_NBANK-1:0] push;
   logic [REBH_LOC_W-1:0] push_loc;
   logic [REBH_NBANK-1:0] hit;

   assign take = I_RD_VALID && state_reg == REBH_ST_IDLE;
   assign is_branch = I_RD.src == REBH_SRC_BRANCH;
   assign is_tcm = I_RD.src == REBH_SRC_ITCM || I_RD.src == REBH_SRC_DTCM;
   assign chk = rebh_secded(I_RD.code);
   assign ecc_err = take && !is_branch && chk.kind != REBH_ERR_NONE;
   assign tcm_first = is_tcm && !O_BANK_NONEMPTY[I_RD.src];

   ////////////////////////////////////////////////////////////////////////////
   // Push requests per bank
   always_comb begin
      push = '0;
      push_loc = I_RD.loc;
      if (state_reg == REBH_ST_SCU_MARK) begin
         push[REBH_SRC_SCU] = 1'b1;
         push[REBH_SRC_DCACHE] = 1'b1;
         push_loc = cap_loc_reg;
      end else if (ecc_err && I_RD.src != REBH_SRC_SCU) begin
         // Later TIGHTLY_COUPLED_MEMORY single errors leave the bank so faults stay isolated
         if (!(is_tcm && chk.kind == REBH_ERR_SINGLE && !tcm_first)) begin
            push[I_RD.src] = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Error banks, one per protected RAM
   for (genvar b = 0; b < REBH_NBANK; b++) begin : g_bank
      localparam logic [1:0] DEPTH = (b == REBH_SRC_SCU) ? REBH_DEPTH_SCU :
         ((b == REBH_SRC_ITCM || b == REBH_SRC_DTCM) ? REBH_DEPTH_TCM : REBH_DEPTH_L1);
      logic [REBH_MAXDEPTH-1:0] slot;
      logic [REBH_MAXDEPTH-1:0] match;

      always_comb begin
         slot = '0;
         for (int e = 0; e < REBH_MAXDEPTH; e++) begin
            if (e < int'(DEPTH) && !vld_reg[b][e] && slot == '0) begin
               slot[e] = 1'b1;
            end
         end
         for (int e = 0; e < REBH_MAXDEPTH; e++) begin
            match[e] = vld_reg[b][e] && loc_reg[b][e] == I_LOOK.loc;
         end
      end
      assign hit[b] = |match;

      always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
         if (!I_RSTN) begin
            vld_reg[b] <= '0;
            loc_reg[b] <= '0;
         end else begin
            for (int e = 0; e < REBH_MAXDEPTH; e++) begin
               // Set wins over a clear aimed at the same entry
               if (push[b] && slot[e]) begin
                  vld_reg[b][e] <= 1'b1;
                  loc_reg[b][e] <= push_loc;
               end else if (I_CLR_VALID && I_CLR.src == b && I_CLR.entry == e) begin
                  vld_reg[b][e] <= 1'b0;
               end
            end
         end
      end

      always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
         if (!I_RSTN) begin
            O_BANK_COUNT[b] <= 2'h0;
            O_BANK_NONEMPTY[b] <= 1'b0;
         end else begin
            O_BANK_COUNT[b] <= 2'(vld_reg[b][0]) + 2'(vld_reg[b][1]) + 2'(vld_reg[b][2]);
            O_BANK_NONEMPTY[b] <= |vld_reg[b];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Lookup masking for reads and allocation
   always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_LOOK_MASKED <= 1'b0;
      end else begin
         O_LOOK_MASKED <= I_LOOK.src <= REBH_SRC_DTCM && hit[I_LOOK.src];
      end
   end

   // TIGHTLY_COUPLED_MEMORY bank copies of corrected data
   always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         tcm_copy_reg <= '0;
      end else if (ecc_err && chk.kind == REBH_ERR_SINGLE && is_tcm && tcm_first) begin
         tcm_copy_reg[I_RD.src == REBH_SRC_DTCM] <= chk.fixed;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Correction sequencer
   always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         state_reg <= REBH_ST_IDLE;
         cap_src_reg <= REBH_SRC_ICACHE;
         cap_loc_reg <= '0;
         cap_fix_reg <= '0;
         cap_bank_reg <= 1'b0;
         O_BUSY <= 1'b0;
         O_MAINT_REQ <= 1'b0;
         O_MAINT_OP <= REBH_OP_INV;
         O_WB_VALID <= 1'b0;
      end else begin
         case (state_reg)
            REBH_ST_IDLE: begin
               // Multi-bit errors on dirty data or TIGHTLY_COUPLED_MEMORY are only reported
               if (ecc_err && (chk.kind == REBH_ERR_SINGLE ||
                   I_RD.src == REBH_SRC_ICACHE || I_RD.src == REBH_SRC_SCU)) begin
                  cap_src_reg <= I_RD.src;
                  cap_loc_reg <= I_RD.loc;
                  cap_fix_reg <= chk.fixed;
                  cap_bank_reg <= tcm_first;
                  O_BUSY <= 1'b1;
                  if (is_tcm) begin
                     state_reg <= REBH_ST_WB;
                     O_WB_VALID <= 1'b1;
                  end else begin
                     state_reg <= REBH_ST_MAINT;
                     O_MAINT_REQ <= 1'b1;
                     // Instruction lines are never dirty
                     O_MAINT_OP <= (I_RD.src == REBH_SRC_ICACHE) ? REBH_OP_INV :
                        REBH_OP_CLEAN_INV;
                  end
               end
            end
            REBH_ST_MAINT: begin
               if (I_MAINT_DONE) begin
                  O_MAINT_REQ <= 1'b0;
                  if (cap_src_reg == REBH_SRC_SCU) begin
                     state_reg <= REBH_ST_SCU_MARK;
                  end else begin
                     state_reg <= REBH_ST_IDLE;
                     O_BUSY <= 1'b0;
                  end
               end
            end
            REBH_ST_WB: begin
               if (I_WB_DONE) begin
                  O_WB_VALID <= 1'b0;
                  state_reg <= REBH_ST_IDLE;
                  O_BUSY <= 1'b0;
               end
            end
            default: begin
               state_reg <= REBH_ST_IDLE;
               O_BUSY <= 1'b0;
            end
         endcase
      end
   end

   // Maintenance target and write back data follow the capture
   assign O_MAINT_LOC = cap_loc_reg;
   assign O_WB_DATA = cap_fix_reg;

   // Retry pulse after the repair completes
   always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_RETRY <= 1'b0;
         O_RETRY_SRC <= REBH_SRC_ICACHE;
         O_RETRY_LOC <= '0;
         O_RETRY_FROM_BANK <= 1'b0;
         O_RETRY_DATA <= '0;
      end else begin
         O_RETRY <= (state_reg == REBH_ST_MAINT && I_MAINT_DONE &&
            cap_src_reg != REBH_SRC_SCU) || state_reg == REBH_ST_SCU_MARK ||
            (state_reg == REBH_ST_WB && I_WB_DONE);
         O_RETRY_SRC <= cap_src_reg;
         O_RETRY_LOC <= cap_loc_reg;
         O_RETRY_FROM_BANK <= state_reg == REBH_ST_WB && cap_bank_reg;
         O_RETRY_DATA <= cap_bank_reg ? tcm_copy_reg[cap_src_reg == REBH_SRC_DTCM] : cap_fix_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Events, counters and the hard fault output
   always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_EVT_CORR <= 1'b0;
         O_EVT_FATAL <= 1'b0;
         O_EVT_PARITY <= 1'b0;
         O_ERR_COUNT <= REBH_CNT_RST;
         O_CORR_COUNT <= REBH_CNT_RST;
      end else begin
         // Snoop tag correctable errors are never notified
         O_EVT_CORR <= ecc_err && chk.kind == REBH_ERR_SINGLE &&
            I_AUX_ECC_EN == REBH_AUX_CORR_ON && I_RD.src != REBH_SRC_SCU;
         // Raised in the cycle after the check, data may already have moved on
         O_EVT_FATAL <= ecc_err && chk.kind == REBH_ERR_MULTI;
         O_EVT_PARITY <= take && is_branch && ^I_RD.code;
         if (ecc_err) begin
            O_ERR_COUNT <= O_ERR_COUNT + 16'h0001;
         end
         if (ecc_err && chk.kind == REBH_ERR_SINGLE) begin
            O_CORR_COUNT <= O_CORR_COUNT + 16'h0001;
         end
      end
   end

   // A repeat error at the last TIGHTLY_COUPLED_MEMORY word written back while its bank was occupied means a hard fault
   always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         watch_reg <= 1'b0;
         watch_src_reg <= REBH_SRC_ICACHE;
         watch_loc_reg <= '0;
         O_RAM_FAULT_OUT <= 1'b0;
      end else if (take && is_tcm) begin
         if (watch_reg && I_RD.src == watch_src_reg && I_RD.loc == watch_loc_reg) begin
            if (chk.kind != REBH_ERR_NONE) begin
               O_RAM_FAULT_OUT <= 1'b1;
            end else begin
               watch_reg <= 1'b0;
            end
         end else if (chk.kind == REBH_ERR_SINGLE && !tcm_first) begin
            watch_reg <= 1'b1;
            watch_src_reg <= I_RD.src;
            watch_loc_reg <= I_RD.loc;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RSTN);

   a_maint_then_retry: assert property (
      (state_reg == REBH_ST_MAINT && I_MAINT_DONE && cap_src_reg != REBH_SRC_SCU)
      |=> O_RETRY && !O_MAINT_REQ)
      else $error("retry missing after maintenance");
   a_retry_not_early: assert property (
      O_MAINT_REQ |-> !O_RETRY)
      else $error("retry during maintenance");
   a_icache_inv_only: assert property (
      (ecc_err && I_RD.src == REBH_SRC_ICACHE) |=> O_MAINT_REQ && O_MAINT_OP == REBH_OP_INV)
      else $error("icache error not invalidate only");
   a_dcache_clean_inv: assert property (
      (ecc_err && chk.kind == REBH_ERR_SINGLE && I_RD.src == REBH_SRC_DCACHE)
      |=> O_MAINT_OP == REBH_OP_CLEAN_INV && O_MAINT_LOC == $past(I_RD.loc))
      else $error("dcache error not cleaned");
   a_tcm_wb_retry: assert property (
      (state_reg == REBH_ST_WB && I_WB_DONE) |=> O_RETRY && !O_WB_VALID)
      else $error("tcm retry missing after write back");
   a_scu_marks: assert property (
      (state_reg == REBH_ST_MAINT && I_MAINT_DONE && cap_src_reg == REBH_SRC_SCU)
      |=> push[REBH_SRC_SCU] && push[REBH_SRC_DCACHE] ##1 O_RETRY)
      else $error("snoop line not marked");
   a_bank_masks: assert property (
      (ecc_err && I_RD.src == REBH_SRC_DCACHE && O_BANK_COUNT[REBH_SRC_DCACHE] == 2'h0
       && !I_CLR_VALID) |=> ##1 O_BANK_COUNT[REBH_SRC_DCACHE] == 2'h1)
      else $error("error not logged");
   a_corr_gated: assert property (
      O_EVT_CORR |-> $past(I_AUX_ECC_EN) == REBH_AUX_CORR_ON)
      else $error("correctable event while checks off");
   a_fatal_always: assert property (
      (ecc_err && chk.kind == REBH_ERR_MULTI) |=> O_EVT_FATAL &&
      O_ERR_COUNT == $past(O_ERR_COUNT) + 16'h0001)
      else $error("fatal error not reported");
   a_fault_sticky: assert property (
      O_RAM_FAULT_OUT |=> O_RAM_FAULT_OUT)
      else $error("ram fault output dropped");
   a_bank_bounded: assert property (
      O_BANK_COUNT[REBH_SRC_SCU] <= REBH_DEPTH_SCU && O_BANK_COUNT[REBH_SRC_ITCM]
      <= REBH_DEPTH_TCM && O_BANK_COUNT[REBH_SRC_DCACHE] <= REBH_DEPTH_L1)
      else $error("bank over depth");

endmodule : rebh_top

// *** rebh_partner.sv ***
// Far-side model answering maintenance and write back requests
`timescale 1ns/1ns
module rebh_partner (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Handshake
   input wire logic i_req,
   input wire logic [3:0] i_dly,
   output logic o_done
);
   logic [3:0] cnt_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // One done pulse per request, after i_dly waiting cycles
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_reg <= 4'h0;
         o_done <= 1'b0;
      end else if (o_done) begin
         // Drop at once, request falls on this edge
         o_done <= 1'b0;
         cnt_reg <= 4'h0;
      end else if (i_req && cnt_reg >= i_dly) begin
         o_done <= 1'b1;
      end else begin
         cnt_reg <= i_req ? cnt_reg + 4'h1 : 4'h0;
      end
   end
endmodule : rebh_partner

// *** rebh_top_test.sv ***
// Self-checking bench for the RAM error bank handler
`timescale 1ns/1ns
module rebh_top_test;
   import rebh_pkg::*;
   typedef struct packed {
      logic [1:0] kind;
      rebh_src_t src;
      logic [REBH_LOC_W-1:0] loc;
      logic fb;
      logic [REBH_CW_W-1:0] data;
   } rebh_note_t;
   localparam logic [1:0] K_RETRY = 2'h0;
   localparam logic [1:0] K_CORR = 2'h1;
   localparam logic [1:0] K_FATAL = 2'h2;
   localparam logic [1:0] K_PAR = 2'h3;

   logic clk, rstn, rd_valid, maint_done, wb_done, clr_valid;
   rebh_rd_t rd_in;
   logic [1:0] aux;
   rebh_clr_t clr;
   rebh_look_t look_in;
   logic busy, maint_req, wb_valid, retry, retry_fb, look_masked;
   logic evt_corr, evt_fatal, evt_par, fault;
   rebh_op_t maint_op;
   rebh_src_t retry_src;
   logic [REBH_LOC_W-1:0] maint_loc, retry_loc, iloc, l2;
   logic [REBH_CW_W-1:0] wb_data, retry_data;
   logic [REBH_NBANK-1:0] nonempty;
   logic [REBH_NBANK-1:0][1:0] bank_cnt;
   logic [REBH_CNT_W-1:0] err_cnt, corr_cnt;
   logic [3:0] dly;
   int n_errors = 0;
   int cmp_count = 0;
   int exp_err = 0;
   int exp_corr = 0;
   int nloc = 0;
   int exp_cnt [5];
   rebh_note_t notes [$];
   rebh_src_t pick [5] = '{REBH_SRC_ICACHE, REBH_SRC_DCACHE, REBH_SRC_ITCM, REBH_SRC_DTCM,
      REBH_SRC_BRANCH};

   rebh_top dut (.I_REF_CLK(clk), .I_RSTN(rstn), .I_RD_VALID(rd_valid), .I_RD(rd_in),
      .I_AUX_ECC_EN(aux), .I_MAINT_DONE(maint_done), .I_WB_DONE(wb_done),
      .I_CLR_VALID(clr_valid), .I_CLR(clr), .I_LOOK(look_in), .O_BUSY(busy),
      .O_MAINT_REQ(maint_req), .O_MAINT_OP(maint_op), .O_MAINT_LOC(maint_loc),
      .O_WB_VALID(wb_valid), .O_WB_DATA(wb_data), .O_RETRY(retry), .O_RETRY_SRC(retry_src),
      .O_RETRY_LOC(retry_loc), .O_RETRY_FROM_BANK(retry_fb), .O_RETRY_DATA(retry_data),
      .O_LOOK_MASKED(look_masked), .O_EVT_CORR(evt_corr), .O_EVT_FATAL(evt_fatal),
      .O_EVT_PARITY(evt_par), .O_RAM_FAULT_OUT(fault), .O_BANK_NONEMPTY(nonempty),
      .O_BANK_COUNT(bank_cnt), .O_ERR_COUNT(err_cnt), .O_CORR_COUNT(corr_cnt));
   rebh_partner pm (.i_clk(clk), .i_rstn(rstn), .i_req(maint_req), .i_dly(dly),
      .o_done(maint_done));
   rebh_partner pw (.i_clk(clk), .i_rstn(rstn), .i_req(wb_valid), .i_dly(dly),
      .o_done(wb_done));

   always #10 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : chk

   task automatic conclude;
      $display("Mismatches %0d, comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude

   // Valid codeword: check bits at power-of-two positions, parity in bit 0
   function automatic logic [REBH_CW_W-1:0] mk_cw(input logic [REBH_CW_W-1:0] r);
      logic [REBH_CW_W-1:0] cw;
      logic [5:0] syn;
      cw = r;
      syn = 6'h00;
      for (int b = 0; b < 6; b++) cw[1 << b] = 1'b0;
      for (int i = 1; i < REBH_CW_W; i++) if (cw[i]) syn = syn ^ 6'(i);
      for (int b = 0; b < 6; b++) cw[1 << b] = syn[b];
      cw[0] = ^cw[REBH_CW_W-1:1];
      return cw;
   endfunction : mk_cw

   function automatic logic [REBH_LOC_W-1:0] nl();
      nloc++;
      return {4'($urandom), 8'(nloc)};
   endfunction : nl

   ////////////////////////////////////////////////////////////////////////////////
   // Driver: one read check, notes expected results, waits out the repair
   task automatic rd(input rebh_src_t s, input bit multi, input logic [1:0] a, input bit poke,
         input logic [REBH_LOC_W-1:0] loc);
      logic [REBH_CW_W-1:0] good, bad;
      int p, t, dep;
      bit ecc, fix, tightly_coupled_memory;
      rebh_note_t n;
      good = mk_cw(REBH_CW_W'({$urandom, $urandom}));
      p = $urandom_range(REBH_CW_W - 1, 1);
      bad = good;
      bad[p] = ~bad[p];
      if (multi) bad[p-1] = ~bad[p-1];
      ecc = s != REBH_SRC_BRANCH;
      tightly_coupled_memory = s == REBH_SRC_ITCM || s == REBH_SRC_DTCM;
      fix = s == REBH_SRC_ICACHE || s == REBH_SRC_SCU || (!multi && ecc);
      dep = tightly_coupled_memory ? 1 : (s == REBH_SRC_SCU ? 2 : 3);
      n = '{!ecc ? K_PAR : (multi ? K_FATAL : K_CORR), s, loc, 1'b0, good};
      if (!(n.kind == K_CORR && (a !== REBH_AUX_CORR_ON || s == REBH_SRC_SCU))) notes.push_back(n);
      n = '{K_RETRY, s, loc, tightly_coupled_memory && exp_cnt[s] == 0, good};
      if (fix) notes.push_back(n);
      if (ecc) exp_err++;
      if (ecc && !multi) exp_corr++;
      if (ecc && exp_cnt[s] < dep) exp_cnt[s]++;
      if (s == REBH_SRC_SCU && exp_cnt[1] < 3) exp_cnt[1]++;
      @(posedge clk);
      dly <= 4'($urandom_range(5, 0));
      aux <= a;
      rd_valid <= 1'b1;
      rd_in <= '{s, loc, bad};
      @(posedge clk);
      rd_valid <= 1'b0;
      if (fix) begin
         t = 0;
         while (maint_req !== 1'b1 && wb_valid !== 1'b1 && t < 8) begin
            @(posedge clk);
            t++;
         end
         chk(64'(t < 8), 1, "repair start");
         if (tightly_coupled_memory) begin
            chk(wb_data, good, "write back data");
         end else begin
            chk(maint_op, s == REBH_SRC_ICACHE ? REBH_OP_INV : REBH_OP_CLEAN_INV, "op");
            chk(maint_loc, loc, "maintenance location");
         end
         if (poke) begin
            // Busy, so this parity error must vanish
            rd_valid <= 1'b1;
            rd_in <= '{REBH_SRC_BRANCH, loc, bad};
            @(posedge clk);
            rd_valid <= 1'b0;
         end
         t = 0;
         while (busy !== 1'b0 && t < 40) begin
            @(posedge clk);
            t++;
         end
         chk(64'(t < 40), 1, "repair end");
         @(posedge clk);
      end else begin
         @(posedge clk);
         chk(busy, 1'b0, "no repair");
         repeat (2) @(posedge clk);
      end
   endtask : rd

   task automatic look(input rebh_src_t s, input logic [REBH_LOC_W-1:0] l, input logic e);
      @(posedge clk);
      look_in <= '{s, l};
      repeat (2) @(posedge clk);
      chk(look_masked, e, "lookup");
   endtask : look

   ////////////////////////////////////////////////////////////////////////////////
   // Watcher: each result takes the oldest note
   task automatic take(input logic [1:0] kind);
      rebh_note_t n;
      if (notes.size() == 0) begin
         chk(kind, 2'h0, "unexpected result");
         chk(1, 0, "unexpected result");
         return;
      end
      n = notes.pop_front();
      chk(kind, n.kind, "result kind");
      if (kind == K_RETRY) begin
         chk(retry_src, n.src, "retry source");
         chk(retry_loc, n.loc, "retry location");
         chk(retry_fb, n.fb, "retry from bank");
         if (n.fb) chk(retry_data, n.data, "retry data");
      end
   endtask : take

   always @(posedge clk) begin
      if (rstn === 1'b1) begin
         if (retry === 1'b1) take(K_RETRY);
         if (evt_corr === 1'b1) take(K_CORR);
         if (evt_fatal === 1'b1) take(K_FATAL);
         if (evt_par === 1'b1) take(K_PAR);
      end
   end

   initial begin
      #400000;
      n_errors++;
      conclude();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      rd_valid = 1'b0;
      rd_in = '0;
      aux = 2'h3;
      clr_valid = 1'b0;
      clr = '0;
      look_in = '0;
      dly = 4'h0;
      for (int i = 0; i < 5; i++) exp_cnt[i] = 0;
      void'($urandom(32'hb2b21cab));
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      chk(nonempty, '0, "reset occupancy");
      iloc = nl();
      rd(REBH_SRC_ICACHE, 0, 2'h3, 1, iloc);
      rd(REBH_SRC_DCACHE, 0, 2'h3, 0, nl());
      rd(REBH_SRC_SCU, 1, 2'h3, 0, nl());
      rd(REBH_SRC_DTCM, 0, 2'h3, 0, nl());
      l2 = nl();
      rd(REBH_SRC_DTCM, 0, 2'h3, 0, l2);
      chk(fault, 1'b0, "fault before hard error");
      rd(REBH_SRC_DTCM, 0, 2'h3, 0, l2);
      chk(fault, 1'b1, "fault after hard error");
      rd(REBH_SRC_ITCM, 0, 2'h3, 0, nl());
      rd(REBH_SRC_DCACHE, 1, 2'h3, 0, nl());
      rd(REBH_SRC_DCACHE, 0, 2'h0, 0, nl());
      rd(REBH_SRC_DTCM, 1, 2'h0, 0, nl());
      for (int k = 0; k < 6; k++) rd(pick[$urandom_range(3, 0)], 0, 2'h3, 0, nl());
      for (int i = 0; i < 5; i++) begin
         chk(bank_cnt[i], exp_cnt[i], "bank count");
         chk(nonempty[i], exp_cnt[i] != 0, "bank occupied");
      end
      chk(err_cnt, exp_err, "error counter");
      chk(corr_cnt, exp_corr, "correctable counter");
      rd(REBH_SRC_BRANCH, 0, 2'h3, 0, nl());
      look(REBH_SRC_ICACHE, iloc, 1'b1);
      look(REBH_SRC_ICACHE, nl(), 1'b0);
      // Monitor frees a soft-error entry, analysis only while nothing runs
      chk(busy, 1'b0, "idle before analysis");
      @(posedge clk);
      clr_valid <= 1'b1;
      clr <= '{REBH_SRC_ICACHE, 2'h0};
      @(posedge clk);
      clr_valid <= 1'b0;
      repeat (3) @(posedge clk);
      chk(bank_cnt[0], exp_cnt[0] - 1, "count after clear");
      look(REBH_SRC_ICACHE, iloc, 1'b0);
      chk(notes.size(), 0, "missing results");
      conclude();
   end
endmodule : rebh_top_test
